// ---- vector_display_controller.sv ----
// Display controller end: shared memory, serial config, sequencer, output buffer
`timescale 1ns/1ps
module vector_display_controller
#(
	parameter int BLANK_MAX_CYCLES = vdc_pkg::BLANK_MAX_CYCLES,
	parameter int VEC_PERIOD = vdc_pkg::VEC_PERIOD_CYCLES,
	parameter int DOT_ON = vdc_pkg::DOT_ON_CYCLES,
	parameter int DEPTH = vdc_pkg::FIFO_DEPTH
)
(
	// Link to processor end
	vdc_if.device link,
	// Converter side
	output logic [vdc_pkg::BYTE_W-1:0] dac_y,
	output logic [vdc_pkg::BYTE_W-1:0] dac_x,
	output logic dac_valid,
	input wire logic dac_ready,
	// Beam and sweep control
	output logic beam_blank,
	output logic vector_en,
	output logic sweep_run,
	// Memory strobes
	output logic mem_rd_strobe,
	output logic mem_wr_strobe
);
	localparam int PW = $clog2(DEPTH);
	localparam int EW = 2 * vdc_pkg::BYTE_W + 1;
	localparam int WDW = $clog2(BLANK_MAX_CYCLES + 1);
	localparam int VPW = $clog2(VEC_PERIOD + 1);
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || VEC_PERIOD < 2 || DOT_ON < 1 || DOT_ON >= VEC_PERIOD
		|| BLANK_MAX_CYCLES <= VEC_PERIOD)
		$error("vector_display_controller: bad parameters");
	typedef enum logic [3:0] {ST_IDLE = 4'h1, ST_BLANK = 4'h2, ST_FETCH = 4'h4, ST_DRAW = 4'h8} seq_e;
	seq_e state;
	logic [vdc_pkg::WORD_W-1:0] mem [vdc_pkg::MEM_WORDS];
	logic [vdc_pkg::CFG_W-1:0] cfg_shift;
	logic [vdc_pkg::CFG_W-1:0] cfg;
	logic ssel_q;
	logic [vdc_pkg::ADDR_W-1:0] disp_addr;
	logic [vdc_pkg::VCNT_W-1:0] vec_cnt;
	logic [vdc_pkg::BCNT_W-1:0] blank_cnt;
	logic [VPW-1:0] period_cnt;
	logic [WDW-1:0] blank_wd;
	logic [EW-1:0] fifo [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0] fill;
	logic pt_blank;
	logic proc_half;
	// Config fields
	logic [vdc_pkg::ADDR_W-1:0] cfg_start;
	logic [vdc_pkg::VCNT_W-1:0] cfg_vcnt;
	logic [vdc_pkg::BCNT_W-1:0] cfg_blank;
	logic [1:0] cfg_mode;
	logic cfg_dot;
	logic cfg_run;
	assign cfg_start = cfg[vdc_pkg::CFG_START_LSB +: vdc_pkg::ADDR_W];
	assign cfg_vcnt = cfg[vdc_pkg::CFG_VCNT_LSB +: vdc_pkg::VCNT_W];
	assign cfg_blank = cfg[vdc_pkg::CFG_BLANK_LSB +: vdc_pkg::BCNT_W];
	assign cfg_mode = cfg[vdc_pkg::CFG_MODE_LSB +: 2];
	assign cfg_dot = cfg[vdc_pkg::CFG_DOT_BIT];
	assign cfg_run = cfg[vdc_pkg::CFG_RUN_BIT];
	// Buffer handshake
	logic push;
	logic pop;
	logic fifo_full;
	logic period_done;
	logic [EW-1:0] next_entry;
	logic [vdc_pkg::WORD_W-1:0] word;
	assign fifo_full = (fill == (PW + 1)'(DEPTH));
	assign dac_valid = (fill != '0);
	assign pop = dac_valid && dac_ready;
	assign period_done = (period_cnt == VPW'(VEC_PERIOD - 1));
	assign word = mem[disp_addr];
	assign push = (state == ST_FETCH) && !proc_half && !fifo_full;
	// Split the word per mode
	always_comb
	begin
		unique case (cfg_mode)
			vdc_pkg::MODE_XY: next_entry = {1'b0, word};
			vdc_pkg::MODE_CHAR: next_entry = {word[0], word[15:1], 1'b0};
			default: next_entry = {1'b0, word[15:8], 8'h00};
		endcase
	end
	// Half-period ownership: processor owns the odd half
	always_ff @(posedge link.pclk or negedge link.presetn)
	begin
		if (!link.presetn)
			proc_half <= 1'b0;
		else
			proc_half <= !proc_half;
	end
	assign link.proc_half = proc_half;
	assign link.disp_busy = (state != ST_IDLE);

	// Processor writes only in its own half
	always_ff @(posedge link.pclk)
	begin
		if (link.mem_we && proc_half)
			mem[link.mem_addr] <= link.mem_wdata;
	end

	always_ff @(posedge link.pclk or negedge link.presetn)
	begin
		if (!link.presetn)
			mem_wr_strobe <= 1'b0;
		else
			mem_wr_strobe <= link.mem_we && proc_half;
	end

	// Serial shift and atomic update
	always_ff @(posedge link.pclk or negedge link.presetn)
	begin
		if (!link.presetn)
		begin
			cfg_shift <= '0;
			cfg <= '0;
			ssel_q <= 1'b0;
		end
		else
		begin
			ssel_q <= link.ssel;
			if (link.ssel && link.sstrobe)
				cfg_shift <= {cfg_shift[vdc_pkg::CFG_W-2:0], link.sdata};
			if (ssel_q && !link.ssel)
				cfg <= cfg_shift;
		end
	end

	// Sequencer
	always_ff @(posedge link.pclk or negedge link.presetn)
	begin
		if (!link.presetn)
			state <= ST_IDLE;
		else
		begin
			unique case (state)
				ST_IDLE:
					if (cfg_run && cfg_vcnt != '0)
						state <= ST_BLANK;
				ST_BLANK:
					if ((period_done && blank_cnt == '0) || blank_wd == WDW'(BLANK_MAX_CYCLES - 1))
						state <= ST_FETCH;
				ST_FETCH:
					if (push)
						state <= ST_DRAW;
				ST_DRAW:
					if (period_done)
						state <= (vec_cnt == cfg_vcnt) ? ST_IDLE : ST_FETCH;
			endcase
		end
	end

	// Vector period timer and blank watchdog
	always_ff @(posedge link.pclk or negedge link.presetn)
	begin
		if (!link.presetn)
		begin
			period_cnt <= '0;
			blank_wd <= '0;
		end
		else
		begin
			if ((state == ST_BLANK || state == ST_DRAW) && !period_done)
				period_cnt <= period_cnt + 1'b1;
			else
				period_cnt <= '0;
			if (beam_blank && state != ST_IDLE)
				blank_wd <= blank_wd + 1'b1;
			else
				blank_wd <= '0;
		end
	end

	// Address, vector and blanking counters
	always_ff @(posedge link.pclk or negedge link.presetn)
	begin
		if (!link.presetn)
		begin
			disp_addr <= '0;
			vec_cnt <= '0;
			blank_cnt <= '0;
		end
		else if (state == ST_IDLE)
		begin
			disp_addr <= cfg_start;
			vec_cnt <= '0;
			blank_cnt <= cfg_blank;
		end
		else
		begin
			if (state == ST_BLANK && period_done && blank_cnt != '0)
				blank_cnt <= blank_cnt - 1'b1;
			if (push)
			begin
				disp_addr <= disp_addr + 1'b1;
				vec_cnt <= vec_cnt + 1'b1;
			end
		end
	end

	assign mem_rd_strobe = push;

	// Two-entry output buffer
	always_ff @(posedge link.pclk)
	begin
		if (push)
			fifo[wr_ptr] <= next_entry;
	end

	always_ff @(posedge link.pclk or negedge link.presetn)
	begin
		if (!link.presetn)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			fill <= fill + (PW + 1)'(push) - (PW + 1)'(pop);
		end
	end

	assign dac_y = fifo[rd_ptr][2*vdc_pkg::BYTE_W-1:vdc_pkg::BYTE_W];
	assign dac_x = fifo[rd_ptr][vdc_pkg::BYTE_W-1:0];

	// Beam controls
	always_ff @(posedge link.pclk or negedge link.presetn)
	begin
		if (!link.presetn)
		begin
			pt_blank <= 1'b0;
			beam_blank <= 1'b1;
			vector_en <= 1'b0;
			sweep_run <= 1'b0;
		end
		else
		begin
			if (pop)
				pt_blank <= fifo[rd_ptr][EW-1];
			vector_en <= (state == ST_DRAW) && !cfg_dot;
			sweep_run <= (state == ST_FETCH || state == ST_DRAW) && cfg_mode == vdc_pkg::MODE_WAVE;
			if (state != ST_DRAW)
				beam_blank <= 1'b1;
			else if (cfg_dot)
				beam_blank <= (period_cnt < VPW'(VEC_PERIOD - DOT_ON)) || pt_blank;
			else
				beam_blank <= pt_blank;
		end
	end
endmodule

// ---- vdc_pkg.sv ----
// Shared constants for the vector display controller and its processor end
package vdc_pkg;
	// Display memory and data widths
	localparam int ADDR_W = 9;
	localparam int WORD_W = 16;
	localparam int BYTE_W = 8;
	localparam int MEM_WORDS = 512;
	localparam int VCNT_W = 9;
	localparam int BCNT_W = 8;
	// Display modes
	localparam logic [1:0] MODE_WAVE = 2'h0;
	localparam logic [1:0] MODE_XY = 2'h1;
	localparam logic [1:0] MODE_CHAR = 2'h2;
	// Serial configuration frame layout, shifted msb first
	localparam int CFG_W = 30;
	localparam int CFG_START_LSB = 0;
	localparam int CFG_VCNT_LSB = 9;
	localparam int CFG_BLANK_LSB = 18;
	localparam int CFG_MODE_LSB = 26;
	localparam int CFG_DOT_BIT = 28;
	localparam int CFG_RUN_BIT = 29;
	// Timing
	localparam int CLK_HZ = 20_000_000;
	localparam int BLANK_MAX_MS = 10;
	localparam int BLANK_MAX_CYCLES = (CLK_HZ / 1000) * BLANK_MAX_MS;
	localparam int VEC_PERIOD_CYCLES = 16;
	localparam int DOT_ON_CYCLES = 4;
	localparam int SCLK_DIV = 4;
	localparam int FIFO_DEPTH = 2;
	// Processor-end APB register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_START = 8'h04;
	localparam logic [7:0] REG_VCOUNT = 8'h08;
	localparam logic [7:0] REG_BLANK = 8'h0c;
	localparam logic [7:0] REG_CMD = 8'h10;
	localparam logic [7:0] REG_MADDR = 8'h14;
	localparam logic [7:0] REG_MDATA = 8'h18;
	localparam logic [7:0] REG_STATUS = 8'h1c;
	// Field positions in CTRL, CMD and STATUS
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_DOT_BIT = 2;
	localparam int CTRL_RUN_BIT = 3;
	localparam int CMD_SEND_BIT = 0;
	localparam int STAT_SER_BIT = 0;
	localparam int STAT_MEM_BIT = 1;
	localparam int STAT_DISP_BIT = 2;
endpackage

// ---- vdc_if.sv ----
// Link between display controller and processor end: memory share and serial control
`timescale 1ns/1ps
interface vdc_if
(
	input wire logic pclk,
	input wire logic presetn
);
	logic proc_half;
	logic disp_busy;
	logic ssel;
	logic sdata;
	logic sstrobe;
	logic [vdc_pkg::ADDR_W-1:0] mem_addr;
	logic [vdc_pkg::WORD_W-1:0] mem_wdata;
	logic mem_we;

	modport device
	(
		input pclk, presetn, ssel, sdata, sstrobe, mem_addr, mem_wdata, mem_we,
		output proc_half, disp_busy
	);
	modport host
	(
		input pclk, presetn, proc_half, disp_busy,
		output ssel, sdata, sstrobe, mem_addr, mem_wdata, mem_we
	);
endinterface

// ---- vdc_processor_end.sv ----
// Processor end: APB registers, memory writer and serial config sender
`timescale 1ns/1ps
module vdc_processor_end
#(
	parameter int SCLK_DIV = vdc_pkg::SCLK_DIV
)
(
	// Link to display controller
	vdc_if.host link,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	localparam int DW = $clog2(SCLK_DIV + 1);
	localparam int BW = $clog2(vdc_pkg::CFG_W + 1);

	if (SCLK_DIV < 2)
		$error("vdc_processor_end: SCLK_DIV below 2");

	logic [3:0] ctrl;
	logic [vdc_pkg::ADDR_W-1:0] start;
	logic [vdc_pkg::VCNT_W-1:0] vcount;
	logic [vdc_pkg::BCNT_W-1:0] blank;
	logic mem_pend;
	logic [vdc_pkg::CFG_W-1:0] shreg;
	logic [BW-1:0] bits_left;
	logic [DW-1:0] div;
	logic tick;
	logic access;
	logic wr_take;
	logic stall;

	assign access = psel && penable;
	assign stall = pwrite && ((paddr == vdc_pkg::REG_MDATA && mem_pend)
		|| (paddr == vdc_pkg::REG_CMD && link.ssel));
	assign pready = !stall;
	assign wr_take = access && pwrite && pready;
	assign tick = (div == DW'(SCLK_DIV - 1));

	// Unmapped offsets answer with an error
	always_comb
	begin
		pslverr = 1'b0;
		prdata = 32'h0000_0000;
		unique case (paddr)
			vdc_pkg::REG_CTRL: prdata = 32'(ctrl);
			vdc_pkg::REG_START: prdata = 32'(start);
			vdc_pkg::REG_VCOUNT: prdata = 32'(vcount);
			vdc_pkg::REG_BLANK: prdata = 32'(blank);
			vdc_pkg::REG_MADDR: prdata = 32'(link.mem_addr);
			vdc_pkg::REG_MDATA: prdata = 32'(link.mem_wdata);
			vdc_pkg::REG_CMD: prdata = 32'h0000_0000;
			vdc_pkg::REG_STATUS: prdata = 32'({link.disp_busy, mem_pend, link.ssel});
			default: pslverr = access;
		endcase
	end

	// Register writes
	always_ff @(posedge link.pclk or negedge link.presetn)
	begin
		if (!link.presetn)
		begin
			ctrl <= '0;
			start <= '0;
			vcount <= '0;
			blank <= '0;
			link.mem_addr <= '0;
			link.mem_wdata <= '0;
		end
		else if (wr_take)
		begin
			if (paddr == vdc_pkg::REG_CTRL)
				ctrl <= pwdata[3:0];
			if (paddr == vdc_pkg::REG_START)
				start <= pwdata[vdc_pkg::ADDR_W-1:0];
			if (paddr == vdc_pkg::REG_VCOUNT)
				vcount <= pwdata[vdc_pkg::VCNT_W-1:0];
			if (paddr == vdc_pkg::REG_BLANK)
				blank <= pwdata[vdc_pkg::BCNT_W-1:0];
			if (paddr == vdc_pkg::REG_MADDR)
				link.mem_addr <= pwdata[vdc_pkg::ADDR_W-1:0];
			if (paddr == vdc_pkg::REG_MDATA)
				link.mem_wdata <= pwdata[vdc_pkg::WORD_W-1:0];
		end
	end

	// Memory write waits for the processor half
	assign link.mem_we = mem_pend && link.proc_half;
	always_ff @(posedge link.pclk or negedge link.presetn)
	begin
		if (!link.presetn)
			mem_pend <= 1'b0;
		else if (wr_take && paddr == vdc_pkg::REG_MDATA)
			mem_pend <= 1'b1;
		else if (link.mem_we)
			mem_pend <= 1'b0;
	end

	// Serial frame sender
	always_ff @(posedge link.pclk or negedge link.presetn)
	begin
		if (!link.presetn)
		begin
			div <= '0;
			shreg <= '0;
			bits_left <= '0;
			link.ssel <= 1'b0;
			link.sdata <= 1'b0;
			link.sstrobe <= 1'b0;
		end
		else
		begin
			div <= tick ? '0 : div + 1'b1;
			link.sstrobe <= 1'b0;
			if (wr_take && paddr == vdc_pkg::REG_CMD && pwdata[vdc_pkg::CMD_SEND_BIT])
			begin
				shreg <= {ctrl[vdc_pkg::CTRL_RUN_BIT], ctrl[vdc_pkg::CTRL_DOT_BIT], ctrl[1:0], blank, vcount, start};
				bits_left <= BW'(vdc_pkg::CFG_W);
				link.ssel <= 1'b1;
			end
			else if (link.ssel && tick)
			begin
				if (bits_left != '0)
				begin
					link.sdata <= shreg[vdc_pkg::CFG_W-1];
					link.sstrobe <= 1'b1;
					shreg <= {shreg[vdc_pkg::CFG_W-2:0], 1'b0};
					bits_left <= bits_left - 1'b1;
				end
				else
					link.ssel <= 1'b0;
			end
		end
	end
endmodule

// ---- vdc_asserts.sv ----
// Concurrent checks on the link between the two ends
`timescale 1ns/1ps
module vdc_asserts
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link signals
	input wire logic proc_half,
	input wire logic disp_busy,
	input wire logic ssel,
	input wire logic sdata,
	input wire logic sstrobe,
	input wire logic [vdc_pkg::ADDR_W-1:0] mem_addr,
	input wire logic [vdc_pkg::WORD_W-1:0] mem_wdata,
	input wire logic mem_we
);
	logic [5:0] nbits;

	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Strobes seen within the current frame
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			nbits <= 6'h00;
		else if (!ssel)
			nbits <= 6'h00;
		else if (sstrobe)
			nbits <= nbits + 6'h01;
	end

	half_alternates_a: assert property ($past(presetn) |-> proc_half != $past(proc_half))
		else $error("memory half did not alternate");
	write_own_half_a: assert property (mem_we |-> proc_half)
		else $error("memory write outside processor half");
	write_single_a: assert property (mem_we |=> !mem_we)
		else $error("memory write held two cycles");
	strobe_selected_a: assert property (sstrobe |-> ssel)
		else $error("serial strobe without select");
	strobe_spacing_a: assert property (sstrobe |=> !sstrobe [*3])
		else $error("serial strobes too close");
	frame_bounded_a: assert property ($rose(ssel) |-> ##[1:200] !ssel)
		else $error("serial frame did not end");
	frame_whole_a: assert property ($fell(ssel) |-> nbits == 6'h1e)
		else $error("frame ended with wrong bit count");
	frame_cap_a: assert property (ssel |-> nbits <= 6'h1e)
		else $error("frame carried too many bits");

	cover property (mem_we);
	cover property ($fell(ssel));
	cover property ($rose(disp_busy));
	cover property (sstrobe && sdata);
endmodule

// ---- tb.sv ----
// Self-checking bench for the display controller and its processor end
`timescale 1ns/1ps
module tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] dac_y;
	logic [7:0] dac_x;
	logic dac_valid;
	logic dac_ready = 1'b0;
	logic beam_blank;
	logic vector_en;
	logic sweep_run;
	logic mem_rd_strobe;
	logic mem_wr_strobe;
	integer seed = 58;
	integer n_fail = 0;
	integer n_compared = 0;
	integer bc = 0;
	integer n_wr = 0;
	int i;
	int m;
	int cnt;
	logic [15:0] mem [512];
	logic [15:0] got [$];
	logic [15:0] w;
	logic [7:0] x;
	logic [8:0] a;
	logic [31:0] r;
	logic e;
	logic dot = 1'b0;

	always #25 pclk = ~pclk;

	vdc_if vdc_if_i(.pclk(pclk), .presetn(presetn));

	vector_display_controller #(.BLANK_MAX_CYCLES(64)) vector_display_controller_i
	(
		.link(vdc_if_i.device),
		.dac_y(dac_y),
		.dac_x(dac_x),
		.dac_valid(dac_valid),
		.dac_ready(dac_ready),
		.beam_blank(beam_blank),
		.vector_en(vector_en),
		.sweep_run(sweep_run),
		.mem_rd_strobe(mem_rd_strobe),
		.mem_wr_strobe(mem_wr_strobe)
	);

	vdc_processor_end vdc_processor_end_i
	(
		.link(vdc_if_i.host),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr)
	);

	vdc_asserts vdc_asserts_i
	(
		.pclk(pclk),
		.presetn(presetn),
		.proc_half(vdc_if_i.proc_half),
		.disp_busy(vdc_if_i.disp_busy),
		.ssel(vdc_if_i.ssel),
		.sdata(vdc_if_i.sdata),
		.sstrobe(vdc_if_i.sstrobe),
		.mem_addr(vdc_if_i.mem_addr),
		.mem_wdata(vdc_if_i.mem_wdata),
		.mem_we(vdc_if_i.mem_we)
	);

	task check(input string what, input logic [31:0] exp, input logic [31:0] seen);
		n_compared++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task conclude;
		if (n_fail == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Random taker stalls, point capture, blanking span watch
	always @(posedge pclk)
	begin
		dac_ready <= 1'($random(seed));
		if (dac_valid === 1'b1 && dac_ready === 1'b1)
			got.push_back({dac_y, dac_x});
		if (mem_wr_strobe === 1'b1)
			n_wr++;
		if (dot && vector_en === 1'b1)
			check("vector_en", 0, 1);
		bc = (beam_blank === 1'b1 && vdc_if_i.disp_busy === 1'b1) ? bc + 1 : 0;
		if (bc > 64)
			check("blank_span", 64, bc);
	end

	initial
	begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		conclude();
	end

	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		// Words across the top of the address space
		for (i = 0; i < 5; i++)
		begin
			a = 9'(510 + i);
			mem[a] = {15'($random(seed)), 1'(i % 2)};
			apb(1'b1, vdc_pkg::REG_MADDR, {23'h0, a});
			apb(1'b1, vdc_pkg::REG_MDATA, {16'h0, mem[a]});
		end
		apb(1'b0, 8'h20, 32'h0);
		check("unmapped_err", 1, e);
		check("unmapped_data", 0, r);
		for (m = 0; m < 3; m++)
		begin
			if (m > 0)
			begin
				@(posedge pclk);
				presetn <= 1'b0;
				repeat (2) @(posedge pclk);
				presetn <= 1'b1;
			end
			dot = (m == 1);
			got.delete();
			apb(1'b1, vdc_pkg::REG_CTRL, {28'h0, 1'b1, dot, 2'(m)});
			apb(1'b1, vdc_pkg::REG_START, 32'h1fe);
			apb(1'b1, vdc_pkg::REG_VCOUNT, 32'h5);
			apb(1'b1, vdc_pkg::REG_BLANK, 32'h2);
			apb(1'b1, vdc_pkg::REG_CMD, 32'h1);
			apb(1'b0, vdc_pkg::REG_STATUS, 32'h0);
			check("status", 32'h1 << vdc_pkg::STAT_SER_BIT, r);
			apb(1'b0, vdc_pkg::REG_VCOUNT, 32'h0);
			check("vcount", 32'h5, r);
			while (vdc_if_i.disp_busy !== 1'b1)
				@(posedge pclk);
			cnt = 0;
			while (mem_rd_strobe !== 1'b1)
			begin
				@(posedge pclk);
				cnt++;
			end
			check("blank_delay", 1, cnt >= 46 && cnt <= 52);
			@(posedge pclk);
			check("sweep_run", 32'(m == 0), sweep_run);
			@(posedge pclk);
			check("vector_en", 32'(m != 1), vector_en);
			while (got.size() < 12)
				@(posedge pclk);
			for (i = 0; i < 12; i++)
			begin
				w = mem[9'(510 + i % 5)];
				x = (m == 0) ? 8'h00 : (m == 1) ? w[7:0] : {w[7:1], 1'b0};
				check("point", {16'h0, w[15:8], x}, {16'h0, got[i]});
			end
		end
		check("wr_strobes", 32'h5, n_wr);
		conclude();
	end
endmodule
